// file: verilog/sbcp_pkg.sv
// constants and enumerations shared by the serial boot command port
package sbcp_pkg;

   // setup exchange bytes
   localparam logic [7:0] SBCP_MATCH1_UART = 8'h86;
   localparam logic [7:0] SBCP_MATCH1_SIO = 8'h30;
   localparam logic [7:0] SBCP_MATCH2_UART = 8'h79;
   localparam logic [7:0] SBCP_MATCH2_SIO = 8'hcf;

   // operation command bytes
   localparam logic [7:0] SBCP_CMD_ERASE = 8'hf0;
   localparam logic [7:0] SBCP_CMD_WRITE = 8'h30;
   localparam logic [7:0] SBCP_CMD_READ = 8'h40;
   localparam logic [7:0] SBCP_CMD_RAMLD = 8'h60;
   localparam logic [7:0] SBCP_CMD_SUM = 8'h90;
   localparam logic [7:0] SBCP_CMD_ID = 8'hc0;
   localparam logic [7:0] SBCP_CMD_STAT = 8'hc3;
   localparam logic [7:0] SBCP_CMD_EMUL = 8'hd0;
   localparam logic [7:0] SBCP_CMD_SECURE = 8'hfa;

   // answer bytes
   localparam logic [7:0] SBCP_CHECK_BYTE = 8'hff;
   localparam logic [7:0] SBCP_ERASED_BYTE = 8'hff;
   localparam logic [7:0] SBCP_ERR_PROTECT = 8'h63;
   localparam logic [2:0] SBCP_ERR_REPEAT = 3'h3;

   // address windows
   localparam logic [15:0] SBCP_ROM_DATA_LO = 16'h1000;
   localparam logic [15:0] SBCP_ROM_DATA_HI = 16'h17ff;
   localparam logic [15:0] SBCP_ROM_CODE_LO = 16'h1000;
   localparam logic [15:0] SBCP_ROM_CODE_HI = 16'h1fff;
   localparam logic [15:0] SBCP_FLASH_LO = 16'h1000;
   localparam logic [15:0] SBCP_FLASH_HI = 16'hffff;
   localparam logic [15:0] SBCP_RAM_LO = 16'h0060;
   localparam logic [15:0] SBCP_RAM_HI = 16'h0c3f;

   // timing
   localparam int SBCP_CLK_HZ = 40000000;
   localparam int SBCP_BAUD_MIN = 9600;
   localparam int SBCP_BAUD_MAX = 128000;
   localparam int SBCP_SIO_MAX_BPS = 250000;
   localparam int SBCP_BIT_CYC_MIN = SBCP_CLK_HZ / SBCP_BAUD_MAX;
   localparam int SBCP_BIT_CYC_MAX = (SBCP_CLK_HZ + SBCP_BAUD_MIN - 1) / SBCP_BAUD_MIN;
   localparam int SBCP_CNT_W = 16;
   localparam int SBCP_SIO_BITS = 8;

   // command sequencer
   typedef enum logic [2:0] {
      SBCP_ST_IDLE = 3'b000,
      SBCP_ST_ECHO1 = 3'b001,
      SBCP_ST_WAIT_M2 = 3'b010,
      SBCP_ST_ECHO2 = 3'b011,
      SBCP_ST_WAIT_CMD = 3'b100,
      SBCP_ST_REPLY = 3'b101,
      SBCP_ST_RUN = 3'b110
   } sbcp_state_t;

   // automatic baud detection on the first byte
   typedef enum logic [2:0] {
      SBCP_AB_ARM = 3'b000,
      SBCP_AB_WAIT = 3'b001,
      SBCP_AB_LOW1 = 3'b010,
      SBCP_AB_HIGH1 = 3'b011,
      SBCP_AB_LOW2 = 3'b100,
      SBCP_AB_TAIL = 3'b101
   } sbcp_ab_t;

   // asynchronous receiver
   typedef enum logic [1:0] {
      SBCP_RX_IDLE = 2'b00,
      SBCP_RX_START = 2'b01,
      SBCP_RX_DATA = 2'b10,
      SBCP_RX_STOP = 2'b11
   } sbcp_rx_t;

endpackage : sbcp_pkg

// file: verilog/sbcp_sio_link.sv
// clocked slave link shifter, running on the controller's serial clock
`timescale 1ns/10ps
`default_nettype none

module sbcp_sio_link
   import sbcp_pkg::*;
(
   input wire logic sclk,
   input wire logic rst_b,
   input wire logic si,
   input wire logic [7:0] tx_byte,
   output logic [7:0] rx_byte,
   output logic rx_tog,
   output logic so_bit
);

   typedef struct packed {
      logic [2:0] cnt;
      logic [7:0] rsh;
      logic [7:0] rbyte;
      logic rtog;
      logic [7:0] tsh;
   } sbcp_link_t;

   sbcp_link_t q, d;

   // one burst is 8 rising edges; the clock stands still between bursts
   always_comb begin
      d = q;
      d.rsh = {si, q.rsh[7:1]};  // lsb first
      d.tsh = {1'b1, q.tsh[7:1]};
      if (q.cnt == 3'h0) begin
         d.tsh = {1'b1, tx_byte[7:1]};  // byte held stable by the core
      end
      if (q.cnt == 3'(SBCP_SIO_BITS - 1)) begin
         d.rbyte = {si, q.rsh[7:1]};  // 8-bit words only
         d.rtog = ~q.rtog;  // burst done, crosses as a toggle
      end
      d.cnt = q.cnt + 3'h1;
   end

   always_ff @(posedge sclk or negedge rst_b) begin
      if (!rst_b) begin
         q <= '0;
      end else begin
         q <= d;
      end
   end

   // first bit must be valid before the first edge of a burst
   assign so_bit = (q.cnt == 3'h0) ? tx_byte[0] : q.tsh[0];
   assign rx_byte = q.rbyte;
   assign rx_tog = q.rtog;

endmodule : sbcp_sio_link

`default_nettype wire

// file: verilog/sbcp_top.sv
// serial boot command port: link selection, autobaud, setup exchange and command decode
`timescale 1ns/10ps
`default_nettype none

module sbcp_top
   import sbcp_pkg::*;
#(
   parameter int BIT_CYC_MAX = SBCP_BIT_CYC_MAX,
   parameter logic [7:0] ID_ROM_CODE = 8'h5a,  // arbitrary value
   parameter logic [7:0] ID_RAM_CODE = 8'h3c  // arbitrary value
)
(
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic SERIAL_CLOCK_INPUT_PIN,
   input wire logic SERIAL_RECEIVE_PIN,
   output logic SERIAL_TRANSMIT_PIN,
   output logic LINK_IS_SIO,
   output logic LINK_READY,
   output logic CMD_START,
   output logic [7:0] CMD_CODE,
   output logic [7:0] CMD_RX_BYTE,
   output logic CMD_RX_VALID,
   input wire logic CMD_BUSY,
   input wire logic CHIP_ERASE_DONE,
   input wire logic FLASH_SECURE_INIT,
   output logic SECURE_ON,
   input wire logic [15:0] FLASH_SUM,
   input wire logic [15:0] CODE_ADDR,
   input wire logic [15:0] DATA_ADDR,
   output logic CODE_ROM_SEL,
   output logic DATA_ROM_SEL,
   input wire logic [15:0] HOST_FLASH_ADDR,
   output logic [15:0] FLASH_ARRAY_ADDR,
   output logic FLASH_ADDR_OK,
   input wire logic [15:0] RAM_ADDR,
   output logic RAM_ADDR_OK,
   input wire logic [7:0] FLASH_RD_DATA,
   input wire logic FLASH_RD_BLANK,
   output logic [7:0] RD_DATA
);

   localparam logic [15:0] LOW1_MIN = 16'(SBCP_BIT_CYC_MIN * 3 / 2);
   localparam logic [15:0] LOW1_MAX = 16'(BIT_CYC_MAX * 5 / 2);
   localparam logic [15:0] CNT_LIM = 16'(BIT_CYC_MAX * 5);

   typedef struct packed {
      sbcp_state_t st;
      sbcp_ab_t ab_st;
      sbcp_rx_t rx_st;
      logic link_set;
      logic link_sio;
      logic [15:0] ab_cnt;
      logic [15:0] low1;
      logic [15:0] bit_cyc;
      logic [15:0] rx_cnt;
      logic [2:0] rx_bit;
      logic [7:0] rx_sh;
      logic rx_valid;
      logic tx_busy;
      logic [15:0] tx_cnt;
      logic [3:0] tx_left;
      logic [9:0] tx_sh;
      logic [7:0] sio_byte;
      logic sio_pend;
      logic [2:0] rt_sync;
      logic [1:0] rxd_sync;
      logic secure;
      logic sec_init;
      logic [7:0] cmd;
      logic refused;
      logic [2:0] idx;
      logic run_arm;
      logic cmd_start;
      logic [7:0] cmd_rx_byte;
      logic cmd_rx_valid;
      logic out_flow;
      logic code_sel;
      logic data_sel;
      logic [15:0] flash_addr;
      logic flash_ok;
      logic ram_ok;
      logic [7:0] rd_data;
   } sbcp_core_t;

   sbcp_core_t q, d;
   logic [7:0] sio_rx_byte;
   logic sio_rx_tog;
   logic sio_so_bit;

   // inclusive window test, used by every address decode
   function automatic logic in_win(input logic [15:0] a, input logic [15:0] lo, input logic [15:0] hi);
      in_win = (a >= lo) && (a <= hi);
   endfunction : in_win

   // number of answer bytes for a command
   function automatic logic [2:0] reply_len(input logic [7:0] c, input logic refused);
      if (refused) begin
         reply_len = SBCP_ERR_REPEAT;
      end else if (c == SBCP_CMD_SUM) begin
         reply_len = 3'h4;
      end else if (c == SBCP_CMD_ID) begin
         reply_len = 3'h3;
      end else if (c == SBCP_CMD_STAT) begin
         reply_len = 3'h2;
      end else begin
         reply_len = 3'h1;
      end
   endfunction : reply_len

   // answer byte number i; byte 0 is the echo of the command, or the protect code when refused
   function automatic logic [7:0] reply_byte(input logic [7:0] c, input logic refused, input logic [2:0] i,
                                             input logic [15:0] sum, input logic sec);
      reply_byte = c;
      if (refused) begin
         reply_byte = SBCP_ERR_PROTECT;
      end else if (c == SBCP_CMD_SUM) begin
         if (i == 3'h1) reply_byte = SBCP_CHECK_BYTE;
         if (i == 3'h2) reply_byte = sum[15:8];  // high byte first
         if (i == 3'h3) reply_byte = sum[7:0];
      end else if (c == SBCP_CMD_ID) begin
         if (i == 3'h1) reply_byte = ID_ROM_CODE;
         if (i == 3'h2) reply_byte = ID_RAM_CODE;
      end else if (c == SBCP_CMD_STAT) begin
         if (i == 3'h1) reply_byte = {7'h00, sec};
      end
   endfunction : reply_byte

   // commands that hand over to the flash and RAM engine
   function automatic logic hands_over(input logic [7:0] c);
      hands_over = (c == SBCP_CMD_ERASE) || (c == SBCP_CMD_WRITE) || (c == SBCP_CMD_READ) ||
                   (c == SBCP_CMD_RAMLD);
   endfunction : hands_over

   function automatic logic known_cmd(input logic [7:0] c);
      known_cmd = hands_over(c) || (c == SBCP_CMD_SUM) || (c == SBCP_CMD_ID) || (c == SBCP_CMD_STAT) ||
                  (c == SBCP_CMD_EMUL) || (c == SBCP_CMD_SECURE);
   endfunction : known_cmd

   sbcp_sio_link u_link (
      .sclk(SERIAL_CLOCK_INPUT_PIN),
      .rst_b(RST_B),
      .si(SERIAL_RECEIVE_PIN),
      .tx_byte(q.sio_byte),
      .rx_byte(sio_rx_byte),
      .rx_tog(sio_rx_tog),
      .so_bit(sio_so_bit)
   );

   // next-state logic of the whole core
   always_comb begin
      logic rxd;
      logic sio_edge;
      logic got;
      logic [7:0] got_byte;
      logic tx_idle;
      logic send;
      logic [7:0] send_val;
      logic ab_done;
      logic sec_set;
      logic sec_clr;
      rxd = q.rxd_sync[1];
      sio_edge = q.rt_sync[2] != q.rt_sync[1];
      got = q.link_sio ? (sio_edge && !q.sio_pend) : q.rx_valid;
      got_byte = q.link_sio ? sio_rx_byte : q.rx_sh;
      tx_idle = !q.tx_busy && !q.sio_pend;
      send = 1'b0;
      send_val = 8'h00;
      ab_done = 1'b0;
      sec_set = 1'b0;
      sec_clr = 1'b0;
      d = q;
      d.cmd_start = 1'b0;
      d.cmd_rx_valid = 1'b0;
      d.rx_valid = 1'b0;

      // pin and toggle synchronisers, first stage feeds only the second
      d.rxd_sync = {q.rxd_sync[0], SERIAL_RECEIVE_PIN};
      d.rt_sync = {q.rt_sync[1:0], sio_rx_tog};

      // a burst that carried our answer out is not a request
      if (sio_edge && q.sio_pend) begin
         d.sio_pend = 1'b0;
      end
      // autobaud: low 2 bits, high 2 bits, low 4 bits, high tail
      if (q.st == SBCP_ST_IDLE) begin
         d.ab_cnt = q.ab_cnt + 16'h0001;
         unique case (q.ab_st)
            SBCP_AB_ARM: begin
               if (rxd) d.ab_st = SBCP_AB_WAIT;
            end
            SBCP_AB_WAIT: begin
               d.ab_cnt = 16'h0001;
               if (!rxd) d.ab_st = SBCP_AB_LOW1;
            end
            SBCP_AB_LOW1: begin
               if (rxd) begin
                  d.low1 = q.ab_cnt;
                  d.ab_cnt = 16'h0001;
                  d.ab_st = (q.ab_cnt < LOW1_MIN) ? SBCP_AB_ARM : SBCP_AB_HIGH1;
               end else if (q.ab_cnt > LOW1_MAX) begin
                  d.ab_st = SBCP_AB_ARM;  // slower than the slowest rate
               end
            end
            SBCP_AB_HIGH1: begin
               if (!rxd) begin
                  d.ab_cnt = 16'h0001;
                  d.ab_st = ((q.ab_cnt >= q.low1 - (q.low1 >> 2)) && (q.ab_cnt <= q.low1 + (q.low1 >> 2))) ?
                            SBCP_AB_LOW2 : SBCP_AB_ARM;
               end else if (q.ab_cnt > CNT_LIM) begin
                  d.ab_st = SBCP_AB_ARM;
               end
            end
            SBCP_AB_LOW2: begin
               if (rxd) begin
                  d.ab_cnt = 16'h0001;
                  d.ab_st = ((q.ab_cnt >= {q.low1[14:0], 1'b0} - (q.low1 >> 1)) &&
                             (q.ab_cnt <= {q.low1[14:0], 1'b0} + (q.low1 >> 1))) ? SBCP_AB_TAIL : SBCP_AB_ARM;
               end else if (q.ab_cnt > CNT_LIM) begin
                  d.ab_st = SBCP_AB_ARM;
               end
            end
            SBCP_AB_TAIL: begin
               if (!rxd) begin
                  d.ab_st = SBCP_AB_ARM;
               end else if (q.ab_cnt >= q.low1) begin
                  ab_done = 1'b1;  // bit 7 and stop seen high
                  d.bit_cyc = q.low1 >> 1;
                  d.ab_st = SBCP_AB_ARM;
               end
            end
            default: d.ab_st = SBCP_AB_ARM;
         endcase
      end

      // asynchronous receiver at the measured rate
      if (q.rx_cnt != 16'h0000) begin
         d.rx_cnt = q.rx_cnt - 16'h0001;
      end
      if (q.link_set && !q.link_sio && q.st != SBCP_ST_IDLE) begin
         unique case (q.rx_st)
            SBCP_RX_IDLE: begin
               if (!rxd) begin
                  d.rx_cnt = q.bit_cyc >> 1;  // sample mid-bit
                  d.rx_st = SBCP_RX_START;
               end
            end
            SBCP_RX_START: begin
               if (q.rx_cnt == 16'h0000) begin
                  d.rx_st = rxd ? SBCP_RX_IDLE : SBCP_RX_DATA;
                  d.rx_cnt = q.bit_cyc - 16'h0001;
                  d.rx_bit = 3'h0;
               end
            end
            SBCP_RX_DATA: begin
               if (q.rx_cnt == 16'h0000) begin
                  d.rx_sh = {rxd, q.rx_sh[7:1]};  // lsb first
                  d.rx_bit = q.rx_bit + 3'h1;
                  d.rx_cnt = q.bit_cyc - 16'h0001;
                  if (q.rx_bit == 3'h7) d.rx_st = SBCP_RX_STOP;
               end
            end
            SBCP_RX_STOP: begin
               if (q.rx_cnt == 16'h0000) begin
                  d.rx_valid = rxd;  // framing error drops the byte
                  d.rx_st = SBCP_RX_IDLE;
               end
            end
         endcase
      end else begin
         d.rx_st = SBCP_RX_IDLE;
      end

      // command sequencer
      unique case (q.st)
         SBCP_ST_IDLE: begin
            if (sio_edge && sio_rx_byte == SBCP_MATCH1_SIO) begin
               d.link_set = 1'b1;
               d.link_sio = 1'b1;
               d.st = SBCP_ST_ECHO1;
            end else if (ab_done) begin
               d.link_set = 1'b1;
               d.link_sio = 1'b0;
               d.st = SBCP_ST_ECHO1;
            end
         end
         SBCP_ST_ECHO1: begin
            if (tx_idle) begin
               send = 1'b1;
               send_val = q.link_sio ? SBCP_MATCH1_SIO : SBCP_MATCH1_UART;
               d.st = SBCP_ST_WAIT_M2;
            end
         end
         SBCP_ST_WAIT_M2: begin
            if (got) begin
               if (got_byte == (q.link_sio ? SBCP_MATCH2_SIO : SBCP_MATCH2_UART)) begin
                  d.st = SBCP_ST_ECHO2;
               end else begin
                  d.st = SBCP_ST_IDLE;  // silent on a wrong match
                  d.link_set = 1'b0;
                  d.link_sio = 1'b0;
                  d.ab_st = SBCP_AB_ARM;
               end
            end
         end
         SBCP_ST_ECHO2: begin
            if (tx_idle) begin
               send = 1'b1;
               send_val = q.link_sio ? SBCP_MATCH2_SIO : SBCP_MATCH2_UART;
               d.st = SBCP_ST_WAIT_CMD;
            end
         end
         SBCP_ST_WAIT_CMD: begin
            if (got && known_cmd(got_byte)) begin
               d.cmd = got_byte;
               d.refused = q.secure && (got_byte == SBCP_CMD_WRITE || got_byte == SBCP_CMD_RAMLD);
               d.idx = 3'h0;
               d.st = SBCP_ST_REPLY;
               if (got_byte == SBCP_CMD_SECURE) sec_set = 1'b1;
            end
         end
         SBCP_ST_REPLY: begin
            if (tx_idle) begin
               if (q.idx == reply_len(q.cmd, q.refused)) begin
                  if (hands_over(q.cmd) && !q.refused) begin
                     d.cmd_start = 1'b1;
                     d.run_arm = 1'b0;
                     d.st = SBCP_ST_RUN;
                  end else begin
                     d.st = SBCP_ST_WAIT_CMD;  // emulation setting has no further effect
                  end
               end else begin
                  send = 1'b1;
                  send_val = reply_byte(q.cmd, q.refused, q.idx, FLASH_SUM, q.secure);
                  d.idx = q.idx + 3'h1;
               end
            end
         end
         SBCP_ST_RUN: begin
            d.run_arm = 1'b1;
            if (got) begin
               d.cmd_rx_byte = got_byte;  // payload to the engine
               d.cmd_rx_valid = 1'b1;
            end
            if (q.run_arm && !CMD_BUSY) d.st = SBCP_ST_WAIT_CMD;
         end
         default: d.st = SBCP_ST_IDLE;
      endcase

      // transmit on the chosen link; uart frame is start, 8 data, stop
      if (q.tx_busy) begin
         d.tx_cnt = q.tx_cnt - 16'h0001;
         if (q.tx_cnt == 16'h0000) begin
            d.tx_sh = {1'b1, q.tx_sh[9:1]};
            d.tx_left = q.tx_left - 4'h1;
            d.tx_cnt = q.bit_cyc - 16'h0001;
            if (q.tx_left == 4'h1) d.tx_busy = 1'b0;
         end
      end
      if (send) begin
         if (q.link_sio) begin
            d.sio_byte = send_val;  // held until the controller clocks it out
            d.sio_pend = 1'b1;
         end else begin
            d.tx_sh = {1'b1, send_val, 1'b0};
            d.tx_left = 4'ha;
            d.tx_cnt = q.bit_cyc - 16'h0001;
            d.tx_busy = 1'b1;
         end
      end

      // security flag: strap at start-up, set beats clear
      sec_clr = CHIP_ERASE_DONE;
      d.secure = sec_set | (q.secure & ~sec_clr);
      if (!q.sec_init) begin
         d.secure = FLASH_SECURE_INIT;
         d.sec_init = 1'b1;
      end

      // flow level: high only when waiting for the next byte
      d.out_flow = (d.st == SBCP_ST_IDLE) || (d.st == SBCP_ST_WAIT_M2) || (d.st == SBCP_ST_WAIT_CMD) ||
                   ((d.st == SBCP_ST_RUN) && !CMD_BUSY && q.run_arm);

      // address decode and translation
      d.code_sel = in_win(CODE_ADDR, SBCP_ROM_CODE_LO, SBCP_ROM_CODE_HI);
      d.data_sel = in_win(DATA_ADDR, SBCP_ROM_DATA_LO, SBCP_ROM_DATA_HI);
      d.flash_ok = in_win(HOST_FLASH_ADDR, SBCP_FLASH_LO, SBCP_FLASH_HI);
      d.flash_addr = HOST_FLASH_ADDR - SBCP_FLASH_LO;  // area offset, bank bit not involved
      d.ram_ok = in_win(RAM_ADDR, SBCP_RAM_LO, SBCP_RAM_HI);
      d.rd_data = FLASH_RD_BLANK ? SBCP_ERASED_BYTE : FLASH_RD_DATA;
   end

   always_ff @(posedge CLK or negedge RST_B) begin
      if (!RST_B) begin
         q <= '0;
         q.tx_sh <= 10'h3ff;  // line idles high
         q.rxd_sync <= 2'h3;
      end else begin
         q <= d;
      end
   end

   // pin: uart line, or in clocked mode the data bit while an answer waits, else flow
   assign SERIAL_TRANSMIT_PIN = !q.link_sio ? q.tx_sh[0] : (q.sio_pend ? sio_so_bit : q.out_flow);
   assign LINK_IS_SIO = q.link_sio;
   assign LINK_READY = (q.st == SBCP_ST_WAIT_CMD);
   assign CMD_START = q.cmd_start;
   assign CMD_CODE = q.cmd;
   assign CMD_RX_BYTE = q.cmd_rx_byte;
   assign CMD_RX_VALID = q.cmd_rx_valid;
   assign SECURE_ON = q.secure;
   assign CODE_ROM_SEL = q.code_sel;
   assign DATA_ROM_SEL = q.data_sel;
   assign FLASH_ARRAY_ADDR = q.flash_addr;
   assign FLASH_ADDR_OK = q.flash_ok;
   assign RAM_ADDR_OK = q.ram_ok;
   assign RD_DATA = q.rd_data;

endmodule : sbcp_top

`default_nettype wire

// file: testbench/sbcp_checker.sv
// concurrent checks on the boot command port pins
`timescale 1ns/10ps
`default_nettype none
module sbcp_chk (
   input wire logic CLK,
   input wire logic RST_B,
   input wire logic [15:0] CODE_ADDR,
   input wire logic [15:0] DATA_ADDR,
   input wire logic [15:0] HOST_FLASH_ADDR,
   input wire logic [15:0] RAM_ADDR,
   input wire logic [15:0] FLASH_ARRAY_ADDR,
   input wire logic CODE_ROM_SEL,
   input wire logic DATA_ROM_SEL,
   input wire logic FLASH_ADDR_OK,
   input wire logic RAM_ADDR_OK,
   input wire logic [7:0] FLASH_RD_DATA,
   input wire logic FLASH_RD_BLANK,
   input wire logic [7:0] RD_DATA,
   input wire logic CMD_START,
   input wire logic [7:0] CMD_CODE,
   input wire logic SECURE_ON
);
   default clocking cb @(posedge CLK); endclocking
   default disable iff (!RST_B);
   // address decodes answer one cycle after their inputs
   a_code_rom_map: assert property (1'b1 |=> CODE_ROM_SEL == ($past(CODE_ADDR) inside {[16'h1000:16'h1fff]}))
      else $error("code rom select wrong");
   a_data_rom_map: assert property (1'b1 |=> DATA_ROM_SEL == ($past(DATA_ADDR) inside {[16'h1000:16'h17ff]}))
      else $error("data rom select wrong");
   a_flash_xlate: assert property (1'b1 |=> FLASH_ADDR_OK == ($past(HOST_FLASH_ADDR) >= 16'h1000) &&
      (!FLASH_ADDR_OK || FLASH_ARRAY_ADDR == $past(HOST_FLASH_ADDR) - 16'h1000)) else $error("flash index wrong");
   a_ram_window: assert property (1'b1 |=> RAM_ADDR_OK == ($past(RAM_ADDR) inside {[16'h0060:16'h0c3f]}))
      else $error("ram window wrong");
   a_erased_read: assert property (1'b1 |=> RD_DATA == ($past(FLASH_RD_BLANK) ? 8'hff : $past(FLASH_RD_DATA)))
      else $error("read data wrong");
   // hand-over pulse carries only engine commands
   a_start_code: assert property (CMD_START |-> CMD_CODE inside {8'hf0, 8'h30, 8'h40, 8'h60})
      else $error("bad command handed over");
   a_start_pulse: assert property (CMD_START |=> !CMD_START)
      else $error("start pulse too long");
   a_secure_refuse: assert property (SECURE_ON && CMD_START |-> CMD_CODE inside {8'hf0, 8'h40})
      else $error("protected command started");
   c_start: cover property (CMD_START);
   c_secure: cover property ($rose(SECURE_ON));
   c_unsecure: cover property ($fell(SECURE_ON));
endmodule : sbcp_chk
bind sbcp_top sbcp_chk u_chk (.*);
`default_nettype wire

// file: testbench/sbcp_host_model.sv
// programming controller model: uart and clocked-link sides
`timescale 1ns/10ps
`default_nettype none
module sbcp_host_model (
   input wire logic clk,
   input wire logic tx,
   output logic rx,
   output logic sclk
);
   localparam int BIT = 320; // host bit time, 125 kbps at 40 MHz
   // lines idle high, clock parked low outside bursts
   initial begin
      rx = 1'b1;
      sclk = 1'b0;
   end
   // start, 8 data lsb first, stop; hands back at mid stop
   task automatic send(input logic [7:0] b);
      logic [9:0] f;
      f = {1'b1, b, 1'b0};
      for (int i = 0; i < 10; i++) begin
         @(posedge clk) rx <= f[i];
         repeat (i == 9 ? BIT / 2 : BIT - 1) @(posedge clk);
      end
   endtask : send
   // sample at mid bit; global timeout guards the wait
   task automatic recv(output logic [7:0] b, output logic s);
      wait (tx === 1'b0);
      repeat (BIT / 2) @(posedge clk);
      for (int i = 0; i < 8; i++) begin
         repeat (BIT) @(posedge clk);
         b[i] = tx;
      end
      repeat (BIT) @(posedge clk);
      s = tx;
   endtask : recv
   // one 8-edge burst, 48 ns clock, reading the pin before each rise
   task automatic sio(input logic [7:0] b, output logic [7:0] r);
      for (int i = 0; i < 8; i++) begin
         rx = b[i];
         r[i] = tx;
         #24 sclk = 1'b1;
         #24 sclk = 1'b0;
      end
      rx = 1'b1;
   endtask : sio
endmodule : sbcp_host_model
`default_nettype wire

// file: testbench/tb_top.sv
// self-checking bench for the serial boot command port
`timescale 1ns/10ps
`default_nettype none
module tb_top;
   logic clk = 0, rst_b = 0, busy = 0, ers = 0, blank = 0, sinit = 0, tx, rx, sclk, sio, rdy, start, rxv, sec;
   logic [15:0] addr = 0, arr;
   logic [7:0] fdat = 0, code, rxb, rdd, b;
   int error_cnt = 0, n_compared = 0, cyc = 0;
   sbcp_top #(.BIT_CYC_MAX(400), .ID_ROM_CODE(8'h5a), .ID_RAM_CODE(8'h3c)) uut (.CLK(clk), .RST_B(rst_b),
      .SERIAL_CLOCK_INPUT_PIN(sclk),
      .SERIAL_RECEIVE_PIN(rx), .SERIAL_TRANSMIT_PIN(tx), .LINK_IS_SIO(sio), .LINK_READY(rdy),
      .CMD_START(start), .CMD_CODE(code), .CMD_RX_BYTE(rxb), .CMD_RX_VALID(rxv), .CMD_BUSY(busy),
      .CHIP_ERASE_DONE(ers), .FLASH_SECURE_INIT(sinit), .SECURE_ON(sec), .FLASH_SUM(16'ha5c3),
      .CODE_ADDR(addr), .DATA_ADDR(addr), .CODE_ROM_SEL(), .DATA_ROM_SEL(), .HOST_FLASH_ADDR(addr),
      .FLASH_ARRAY_ADDR(arr), .FLASH_ADDR_OK(), .RAM_ADDR(addr), .RAM_ADDR_OK(),
      .FLASH_RD_DATA(fdat), .FLASH_RD_BLANK(blank), .RD_DATA(rdd));
   sbcp_host_model u_host (.clk(clk), .tx(tx), .rx(rx), .sclk(sclk));
   // 40 MHz core clock and run-length guard
   always #12.5 clk = ~clk;
   always @(posedge clk) begin
      cyc <= cyc + 1;
      if (cyc == 99000) begin
         error_cnt++;
         print_verdict();
      end
   end
   task automatic chk(string nm, logic [15:0] e, logic [15:0] g);
      n_compared++;
      if (g !== e) begin
         error_cnt++;
         $display("Error %s expected %h seen %h", nm, e, g);
      end
   endtask : chk
   // command byte then n answer bytes, left-aligned in e
   task automatic xfer(logic [7:0] c, logic [31:0] e, int n);
      logic s;
      u_host.send(c);
      for (int i = 0; i < n; i++) begin
         u_host.recv(b, s);
         chk("answer", {8'h0, e[31-8*i -: 8]}, {8'h0, b});
         chk("stop bit", 16'h1, {15'h0, s});
      end
   endtask : xfer
   // engine command: echo, hand-over, optional payload, return to ready
   task automatic run(logic [7:0] c, logic pay);
      xfer(c, {c, 24'h0}, 1);
      do @(posedge clk); while (start !== 1'b1);
      chk("command", {8'h0, c}, {8'h0, code});
      busy <= 1'b1;
      if (pay) begin
         u_host.send(8'h5a); // plain data, no flash area switching in it
         do @(posedge clk); while (rxv !== 1'b1);
         chk("payload", 16'h5a, {8'h0, rxb});
      end
      @(posedge clk) busy <= 1'b0;
      do @(posedge clk); while (rdy !== 1'b1);
   endtask : run
   // boundary addresses; blank flag follows bit 0
   task automatic addr_map();
      logic [15:0] t [6] = '{16'h0fff, 16'h1000, 16'h17ff, 16'h1fff, 16'h005f, 16'h0c3f};
      foreach (t[i]) begin
         @(posedge clk) {addr, fdat, blank} <= {t[i], t[i][7:0], t[i][0]};
         repeat (2) @(posedge clk);
         chk("read data", t[i][0] ? 16'h00ff : {8'h0, t[i][7:0]}, {8'h0, rdd});
         if (t[i] >= 16'h1000) chk("flash index", t[i] - 16'h1000, arr);
      end
   endtask : addr_map
   task automatic pulse_erase();
      @(posedge clk) ers <= 1'b1;
      @(posedge clk) ers <= 1'b0;
      repeat (3) @(posedge clk);
   endtask : pulse_erase
   // clocked link after a second reset; answer read in a later burst
   task automatic sio_setup();
      @(posedge clk) {rst_b, sinit} <= 2'b01;
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (20) @(posedge clk);
      chk("secure init", 16'h1, {15'h0, sec});
      wait (tx === 1'b1);
      u_host.sio(8'h30, b);
      repeat (200) @(posedge clk);
      u_host.sio(8'hff, b);
      chk("sio echo", 16'h30, {8'h0, b});
      chk("link", 16'h1, {15'h0, sio});
   endtask : sio_setup
   task automatic print_verdict();
      if (error_cnt == 0 && n_compared > 0) begin
         $display("== PASSED ==");
      end else begin
         $display("== FAILED ==");
      end
      $finish;
   endtask : print_verdict
   // main sequence
   initial begin
      repeat (10) @(posedge clk);
      rst_b <= 1'b1;
      repeat (20) @(posedge clk);
      addr_map();
      xfer(8'h86, 32'h86000000, 1);
      xfer(8'h79, 32'h79000000, 1);
      run(8'hf0, 1'b1);
      run(8'h30, 1'b0);
      xfer(8'hfa, 32'hfa000000, 1);
      xfer(8'hc3, 32'hc3010000, 2);
      xfer(8'h60, 32'h63636300, 3);
      run(8'h40, 1'b0); // read still allowed while protected
      pulse_erase();
      chk("secure", 16'h0, {15'h0, sec});
      xfer(8'h90, 32'h90ffa5c3, 4);
      xfer(8'hc0, 32'hc05a3c00, 3);
      xfer(8'hd0, 32'hd0000000, 1);
      sio_setup();
      print_verdict();
   end
endmodule : tb_top
`default_nettype wire
